// [hw/sfr_pkg.sv]
package sfr_pkg;

	// ---------------------------------------------------------------
	// Recovery pattern frame lengths
	// ---------------------------------------------------------------
	localparam logic [5:0] FRAME_A_CLOCKS      = 6'h07;
	localparam logic [5:0] FRAME_B_CLOCKS      = 6'h0D;
	localparam logic [5:0] FRAME_C_CLOCKS      = 6'h19;
	localparam logic [5:0] FRAME_PROTO_CLOCKS  = 6'h08;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int         CLK_PERIOD_NS       = 40;
	localparam int         DESELECT_TIME_NS    = 50;
	localparam int         DESELECT_CYCLES     =
		(DESELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int         SCLK_DIV            = 4;

	// ---------------------------------------------------------------
	// Execute-in-place framing and delivery state
	// ---------------------------------------------------------------
	localparam logic [5:0] EXEC_ADDR_BITS      = 6'h18;
	localparam logic [7:0] ARRAY_ERASED        = 8'hFF;
	localparam logic [7:0] STATUS_DELIVERED    = 8'h00;
	localparam logic       EXEC_AT_POWER_UP    = 1'h1;
	localparam logic       QUAD_AT_POWER_UP    = 1'h1;

	typedef enum logic [2:0] {
		SFR_TRK_IDLE  = 3'h0,
		SFR_TRK_GOT_A = 3'h1,
		SFR_TRK_GOT_B = 3'h3,
		SFR_TRK_GOT_C = 3'h2,
		SFR_TRK_DONE  = 3'h6
	} sfr_trk_t;

	typedef enum logic [2:0] {
		SFR_HST_IDLE  = 3'h0,
		SFR_HST_LOW   = 3'h1,
		SFR_HST_HIGH  = 3'h3,
		SFR_HST_GAP   = 3'h2,
		SFR_HST_DONE  = 3'h6
	} sfr_hst_t;

endpackage

// [hw/sfr_link_if.sv]
`timescale 1ns/1ns
interface sfr_link_if;
	logic sclk;
	logic chip_select_n;
	logic serial_data_line_zero;
	logic data_line_three_hold;
	logic data_out;

	modport host (
		output sclk,
		output chip_select_n,
		output serial_data_line_zero,
		output data_line_three_hold,
		input  data_out
	);

	modport memory (
		input  sclk,
		input  chip_select_n,
		input  serial_data_line_zero,
		input  data_line_three_hold,
		output data_out
	);
endinterface

// [hw/sfr_memory.sv]
`timescale 1ns/1ns
// How it works
// RULE1: Frames of 7,13,25 clocks end execute-in-place.
// RULE2: Host raises select before the next clock.
// RULE3: One 8-clock frame with line three forces serial.
// RULE4: Host sends exit frames before protocol frame.
// RULE5: Host keeps select high 50 ns between frames.
// RULE6: Recovered state holds until next power-up.
// RULE7: Host may rewrite nonvolatile configuration afterwards.
// RULE8: Erased array reads FFh everywhere.
// RULE9: Delivered status register reads 00h.
// RULE10: In execute-in-place, first 24 bits are address.
// RULE11: First dummy bit one leaves execute-in-place.
// RULE12: Count clocks, clear on select rise, track lengths.
module sfr_memory #(
	parameter int DUMMY_CLOCKS = 8
) (
	// System
	input  wire logic ref_clk_in,
	input  wire logic srst_in,
	// Link
	sfr_link_if.memory link,
	// Status
	output logic      exec_active_out,
	output logic      quad_active_out,
	output logic      recovered_out,
	output logic [7:0] status_reg_out
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] sclk_sync_q;
	logic [1:0] cs_sync_q;
	logic [1:0] d0_sync_q;
	logic [1:0] d3_sync_q;
	logic       sclk_last_q;
	logic       cs_last_q;

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			sclk_sync_q <= 2'h0;
			cs_sync_q   <= 2'h3;
			d0_sync_q   <= 2'h0;
			d3_sync_q   <= 2'h0;
			sclk_last_q <= 1'h0;
			cs_last_q   <= 1'h1;
		end else begin
			sclk_sync_q <= {sclk_sync_q[0], link.sclk};
			cs_sync_q   <= {cs_sync_q[0], link.chip_select_n};
			d0_sync_q   <= {d0_sync_q[0], link.serial_data_line_zero};
			d3_sync_q   <= {d3_sync_q[0], link.data_line_three_hold};
			sclk_last_q <= sclk_sync_q[1];
			cs_last_q   <= cs_sync_q[1];
		end
	end

	// Data is sampled with the synchronised clock, so the bench must keep data
	// stable across the rising edge of the serial clock.
	logic sclk_rise;
	logic cs_rise;
	logic cs_fall;
	logic selected;
	assign sclk_rise = sclk_sync_q[1] && !sclk_last_q;
	assign cs_rise   = cs_sync_q[1] && !cs_last_q;
	assign cs_fall   = !cs_sync_q[1] && cs_last_q;
	assign selected  = !cs_sync_q[1];

	// ---------------------------------------------------------------
	// Frame clock counter and line-high qualifiers
	// ---------------------------------------------------------------
	logic [5:0] clk_count_q;
	logic       d0_all_high_q;
	logic       d3_all_high_q;

	always_ff @(posedge ref_clk_in) begin
		if (srst_in || cs_rise || cs_fall) begin
			clk_count_q <= 6'h00; // RULE12
		end else if (selected && sclk_rise && clk_count_q != 6'h3F) begin
			clk_count_q <= clk_count_q + 6'h01; // RULE12
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in || cs_fall) begin
			d0_all_high_q <= 1'h1;
			d3_all_high_q <= 1'h1;
		end else if (selected && sclk_rise) begin
			d0_all_high_q <= d0_all_high_q && d0_sync_q[1];
			d3_all_high_q <= d3_all_high_q && d3_sync_q[1];
		end
	end

	function automatic logic frame_is(input logic [5:0] cnt, input logic [5:0] len);
		return cnt == len;
	endfunction

	// ---------------------------------------------------------------
	// Recovery pattern tracker
	// ---------------------------------------------------------------
	sfr_pkg::sfr_trk_t trk_q;
	logic              d0_ok;
	assign d0_ok = d0_all_high_q;

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			trk_q <= sfr_pkg::SFR_TRK_IDLE;
		end else if (cs_rise) begin
			case (trk_q)
				sfr_pkg::SFR_TRK_IDLE: begin
					if (d0_ok && frame_is(clk_count_q, sfr_pkg::FRAME_A_CLOCKS)) begin
						trk_q <= sfr_pkg::SFR_TRK_GOT_A; // RULE1
					end
				end
				sfr_pkg::SFR_TRK_GOT_A: begin
					if (d0_ok && frame_is(clk_count_q, sfr_pkg::FRAME_B_CLOCKS)) begin
						trk_q <= sfr_pkg::SFR_TRK_GOT_B; // RULE1
					end else begin
						trk_q <= sfr_pkg::SFR_TRK_IDLE;
					end
				end
				sfr_pkg::SFR_TRK_GOT_B: begin
					if (d0_ok && frame_is(clk_count_q, sfr_pkg::FRAME_C_CLOCKS)) begin
						trk_q <= sfr_pkg::SFR_TRK_GOT_C; // RULE1
					end else begin
						trk_q <= sfr_pkg::SFR_TRK_IDLE;
					end
				end
				sfr_pkg::SFR_TRK_GOT_C: begin
					if (d0_ok && d3_all_high_q
						&& frame_is(clk_count_q, sfr_pkg::FRAME_PROTO_CLOCKS)) begin
						trk_q <= sfr_pkg::SFR_TRK_DONE; // RULE3
					end
				end
				sfr_pkg::SFR_TRK_DONE: begin
					trk_q <= sfr_pkg::SFR_TRK_DONE; // RULE6
				end
				default: begin
					trk_q <= sfr_pkg::SFR_TRK_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Mode state
	// ---------------------------------------------------------------
	// Power-up mode models an undefined nonvolatile setting: both modes on.
	logic       exec_q;
	logic       quad_q;
	logic       exit_pending_q;
	logic [5:0] exec_confirm_pos;
	assign exec_confirm_pos = sfr_pkg::EXEC_ADDR_BITS + 6'h01;

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			exit_pending_q <= 1'h0;
		end else if (cs_fall) begin
			exit_pending_q <= 1'h0;
		end else if (exec_q && selected && sclk_rise
			&& clk_count_q == sfr_pkg::EXEC_ADDR_BITS) begin
			exit_pending_q <= d0_sync_q[1]; // RULE11
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			exec_q <= sfr_pkg::EXEC_AT_POWER_UP;
		end else if (trk_q == sfr_pkg::SFR_TRK_GOT_C
			|| trk_q == sfr_pkg::SFR_TRK_DONE) begin
			exec_q <= 1'h0; // RULE1 RULE6
		end else if (cs_rise && exit_pending_q) begin
			exec_q <= 1'h0; // RULE11
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			quad_q <= sfr_pkg::QUAD_AT_POWER_UP;
		end else if (trk_q == sfr_pkg::SFR_TRK_DONE) begin
			quad_q <= 1'h0; // RULE3 RULE6
		end
	end

	// ---------------------------------------------------------------
	// Execute-in-place read: address then dummies then erased data
	// ---------------------------------------------------------------
	// Address bits only move the count on: every location of an erased
	// array reads the same, so no address is kept.
	logic       dout_q;
	logic [5:0] data_start;
	assign data_start = exec_confirm_pos + 6'(DUMMY_CLOCKS - 1); // RULE10

	always_ff @(posedge ref_clk_in) begin
		if (srst_in || !selected) begin
			dout_q <= 1'h0;
		end else if (exec_q && clk_count_q >= data_start) begin
			dout_q <= sfr_pkg::ARRAY_ERASED[3'(clk_count_q)]; // RULE8 RULE10
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			exec_active_out <= sfr_pkg::EXEC_AT_POWER_UP;
			quad_active_out <= sfr_pkg::QUAD_AT_POWER_UP;
			recovered_out   <= 1'h0;
			status_reg_out  <= sfr_pkg::STATUS_DELIVERED; // RULE9
		end else begin
			exec_active_out <= exec_q;
			quad_active_out <= quad_q;
			recovered_out   <= trk_q == sfr_pkg::SFR_TRK_DONE;
			status_reg_out  <= sfr_pkg::STATUS_DELIVERED; // RULE9
		end
	end

	assign link.data_out = dout_q;

endmodule

// [hw/sfr_host.sv]
`timescale 1ns/1ns
module sfr_host (
	// System
	input  wire logic ref_clk_in,
	input  wire logic srst_in,
	// User
	input  wire logic start_in,
	output logic      busy_out,
	output logic      done_out,
	// Link
	sfr_link_if.host  link
);

	// ---------------------------------------------------------------
	// Frame sequencer
	// ---------------------------------------------------------------
	sfr_pkg::sfr_hst_t st_q;
	logic [1:0]        frame_q;
	logic [5:0]        sent_q;
	logic [3:0]        div_q;
	logic [3:0]        gap_q;
	logic              sclk_q;
	logic              cs_n_q;
	logic              d0_q;
	logic              d3_q;

	// Frames go out in the fixed order below, exit pattern first.
	function automatic logic [5:0] frame_len(input logic [1:0] idx);
		case (idx)
			2'h0:    return sfr_pkg::FRAME_A_CLOCKS; // RULE1 RULE4
			2'h1:    return sfr_pkg::FRAME_B_CLOCKS;
			2'h2:    return sfr_pkg::FRAME_C_CLOCKS;
			default: return sfr_pkg::FRAME_PROTO_CLOCKS; // RULE3 RULE4
		endcase
	endfunction

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			st_q    <= sfr_pkg::SFR_HST_IDLE;
			frame_q <= 2'h0;
			sent_q  <= 6'h00;
			div_q   <= 4'h0;
			gap_q   <= 4'h0;
			sclk_q  <= 1'h0;
			cs_n_q  <= 1'h1;
			d0_q    <= 1'h0;
			d3_q    <= 1'h0;
		end else begin
			case (st_q)
				sfr_pkg::SFR_HST_IDLE: begin
					if (start_in) begin
						st_q    <= sfr_pkg::SFR_HST_LOW;
						frame_q <= 2'h0;
						sent_q  <= 6'h00;
						div_q   <= 4'h0;
						cs_n_q  <= 1'h0;
						d0_q    <= 1'h1; // RULE1
						d3_q    <= 1'h0;
					end
				end
				sfr_pkg::SFR_HST_LOW: begin
					if (div_q == 4'(sfr_pkg::SCLK_DIV - 1)) begin
						div_q <= 4'h0;
						if (sent_q == frame_len(frame_q)) begin
							cs_n_q <= 1'h1; // RULE2
							gap_q  <= 4'h0;
							st_q   <= sfr_pkg::SFR_HST_GAP;
						end else begin
							sclk_q <= 1'h1;
							sent_q <= sent_q + 6'h01;
							st_q   <= sfr_pkg::SFR_HST_HIGH;
						end
					end else begin
						div_q <= div_q + 4'h1;
					end
				end
				sfr_pkg::SFR_HST_HIGH: begin
					if (div_q == 4'(sfr_pkg::SCLK_DIV - 1)) begin
						div_q  <= 4'h0;
						sclk_q <= 1'h0;
						st_q   <= sfr_pkg::SFR_HST_LOW;
					end else begin
						div_q <= div_q + 4'h1;
					end
				end
				sfr_pkg::SFR_HST_GAP: begin
					// The gap is stretched well past the minimum so the far
					// end's synchronisers see every select edge.
					if (gap_q == 4'(sfr_pkg::DESELECT_CYCLES + 4)) begin // RULE5
						if (frame_q == 2'h3) begin
							st_q <= sfr_pkg::SFR_HST_DONE;
							d0_q <= 1'h0;
							d3_q <= 1'h0;
						end else begin
							frame_q <= frame_q + 2'h1;
							sent_q  <= 6'h00;
							cs_n_q  <= 1'h0;
							d3_q    <= frame_q == 2'h2; // RULE3
							st_q    <= sfr_pkg::SFR_HST_LOW;
						end
					end else begin
						gap_q <= gap_q + 4'h1;
					end
				end
				sfr_pkg::SFR_HST_DONE: begin
					st_q <= sfr_pkg::SFR_HST_IDLE;
				end
				default: begin
					st_q <= sfr_pkg::SFR_HST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			busy_out <= 1'h0;
			done_out <= 1'h0;
		end else begin
			busy_out <= st_q != sfr_pkg::SFR_HST_IDLE && st_q != sfr_pkg::SFR_HST_DONE;
			// Done marks the moment to rewrite the nonvolatile configuration for good.
			done_out <= st_q == sfr_pkg::SFR_HST_DONE; // RULE7
		end
	end

	assign link.sclk                  = sclk_q;
	assign link.chip_select_n         = cs_n_q;
	assign link.serial_data_line_zero = d0_q;
	assign link.data_line_three_hold  = d3_q;

endmodule

// [tb/sfr_chk.sv]
`timescale 1ns/1ns
module sfr_chk (
	// System
	input  wire logic ref_clk_in,
	input  wire logic srst_in,
	// Link
	input  wire logic sclk,
	input  wire logic chip_select_n,
	input  wire logic serial_data_line_zero,
	input  wire logic data_line_three_hold
);
	// ---------------------------------------------------------------
	// Frame bookkeeping
	// ---------------------------------------------------------------
	logic [5:0] edges_q;
	logic [1:0] frame_q;
	logic       sclk_q;
	logic [5:0] want;

	always_ff @(posedge ref_clk_in) begin
		sclk_q <= sclk;
	end
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || chip_select_n) begin
			edges_q <= 6'h00;
		end else if (sclk && !sclk_q) begin
			edges_q <= edges_q + 6'h01;
		end
	end
	// The frame index wraps, so a repeated recovery run is judged again from its first frame.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			frame_q <= 2'h0;
		end else if ($rose(chip_select_n)) begin
			frame_q <= frame_q + 2'h1;
		end
	end
	always_comb begin
		case (frame_q)
			2'h0:    want = sfr_pkg::FRAME_A_CLOCKS;
			2'h1:    want = sfr_pkg::FRAME_B_CLOCKS;
			2'h2:    want = sfr_pkg::FRAME_C_CLOCKS;
			default: want = sfr_pkg::FRAME_PROTO_CLOCKS;
		endcase
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);

	sequence s_high_half;
		sclk [*4] ##1 !sclk;
	endsequence
	sequence s_lead_in;
		!sclk ##[1:8] sclk;
	endsequence

	chk_select_rise_low: assert property ($rose(chip_select_n) |-> !sclk)
		else $error("select rose with clock high");
	chk_gap_min: assert property ($rose(chip_select_n) |-> chip_select_n [*2])
		else $error("deselect gap too short");
	chk_clock_quiet: assert property (chip_select_n && $past(chip_select_n) |-> !sclk)
		else $error("clock moved while deselected");
	chk_line_zero_high: assert property (!chip_select_n |-> serial_data_line_zero)
		else $error("data line zero low in frame");
	chk_frame_length: assert property (
		$rose(chip_select_n) |-> edges_q == want)
		else $error("frame length wrong");
	chk_line_three_frame: assert property (
		!chip_select_n |-> data_line_three_hold == (frame_q == 2'h3))
		else $error("line three wrong for frame");
	chk_clock_high_half: assert property ($rose(sclk) |-> s_high_half)
		else $error("clock high half wrong");
	chk_frame_lead_in: assert property ($fell(chip_select_n) |-> s_lead_in)
		else $error("no clock after select");
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
	typedef struct packed {
		logic [5:0] clocks;
		logic       d0;
		logic       d3;
		logic       ex;
		logic       quad;
		logic       rec;
	} sfr_row_t;

	logic       ref_clk_in = 1'h0;
	logic       srst_in    = 1'h1;
	logic       start_in   = 1'h0;
	logic       busy;
	logic       done;
	logic       exec_a;
	logic       quad_a;
	logic       rec_a;
	logic [7:0] stat_a;
	logic       exec_b;
	logic       quad_b;
	logic       rec_b;
	logic [7:0] stat_b;
	logic       last_dout;
	logic [7:0] dones;
	int         mismatches = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	sfr_row_t   rows [11];

	sfr_link_if link_a ();
	sfr_link_if link_b ();

	always #20 ref_clk_in = ~ref_clk_in;

	sfr_host sfr_host_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .start_in(start_in),
		.busy_out(busy), .done_out(done), .link(link_a));
	sfr_memory #(.DUMMY_CLOCKS(8)) sfr_memory_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
		.link(link_a), .exec_active_out(exec_a), .quad_active_out(quad_a),
		.recovered_out(rec_a), .status_reg_out(stat_a));
	// A second memory faces the bench, so frames of wrong length and order can be sent.
	sfr_memory #(.DUMMY_CLOCKS(8)) sfr_memory_b_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
		.link(link_b), .exec_active_out(exec_b), .quad_active_out(quad_b),
		.recovered_out(rec_b), .status_reg_out(stat_b));
	sfr_chk sfr_chk_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .sclk(link_a.sclk),
		.chip_select_n(link_a.chip_select_n),
		.serial_data_line_zero(link_a.serial_data_line_zero),
		.data_line_three_hold(link_a.data_line_three_hold));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Released data lines show the inverse level, so a stale value can never pass.
	task automatic send_frame(input logic [5:0] n, input logic d0, input logic d3);
		@(posedge ref_clk_in);
		link_b.chip_select_n         <= 1'h0;
		link_b.serial_data_line_zero <= d0;
		link_b.data_line_three_hold  <= d3;
		repeat (4) @(posedge ref_clk_in);
		for (int i = 0; i < n; i++) begin
			link_b.sclk <= 1'h1;
			repeat (4) @(posedge ref_clk_in);
			link_b.sclk <= 1'h0;
			repeat (4) @(posedge ref_clk_in);
		end
		@(negedge ref_clk_in);
		last_dout = link_b.data_out;
		@(posedge ref_clk_in);
		link_b.chip_select_n         <= 1'h1;
		link_b.serial_data_line_zero <= ~d0;
		link_b.data_line_three_hold  <= ~d3;
		repeat (8) @(posedge ref_clk_in);
	endtask
	task automatic do_reset();
		srst_in <= 1'h1;
		repeat (12) @(posedge ref_clk_in);
		srst_in <= 1'h0;
		@(posedge ref_clk_in);
	endtask

	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 10000) begin
			mismatches++;
			test_done();
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		link_b.sclk = 1'h0;
		link_b.chip_select_n = 1'h1;
		link_b.serial_data_line_zero = 1'h0;
		link_b.data_line_three_hold = 1'h0;
		rows = '{
			'{6'h08, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0}, '{6'h07, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0},
			'{6'h0D, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0}, '{6'h18, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0},
			'{6'h08, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0}, '{6'h07, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0},
			'{6'h0D, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0}, '{6'h19, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
			'{6'h08, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1}, '{6'h28, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1},
			'{6'h08, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1}};
		do_reset();
		cmp1(exec_a, sfr_pkg::EXEC_AT_POWER_UP);
		cmp1(quad_a, sfr_pkg::QUAD_AT_POWER_UP);
		cmp8(stat_a, sfr_pkg::STATUS_DELIVERED);
		start_in <= 1'h1;
		@(posedge ref_clk_in);
		start_in <= 1'h0;
		repeat (20) @(posedge ref_clk_in);
		cmp1(busy, 1'h1);
		start_in <= 1'h1;
		@(posedge ref_clk_in);
		start_in <= 1'h0;
		dones = 8'h00;
		repeat (1200) begin
			@(posedge ref_clk_in);
			if (done === 1'h1) dones = dones + 8'h01;
		end
		cmp8(dones, 8'h01);
		cmp1(exec_a, 1'h0);
		cmp1(quad_a, 1'h0);
		cmp1(rec_a, 1'h1);
		foreach (rows[r]) begin
			send_frame(rows[r].clocks, rows[r].d0, rows[r].d3);
			cmp1(exec_b, rows[r].ex);
			cmp1(quad_b, rows[r].quad);
			cmp1(rec_b, rows[r].rec);
		end
		do_reset();
		cmp1(exec_b, 1'h1);
		cmp1(rec_b, 1'h0);
		send_frame(6'h1F, 1'h0, 1'h0);
		cmp1(last_dout, 1'h0);
		send_frame(6'h20, 1'h0, 1'h0);
		cmp1(last_dout, sfr_pkg::ARRAY_ERASED[0]);
		cmp1(exec_b, 1'h1);
		send_frame(6'h19, 1'h1, 1'h0);
		cmp1(exec_b, 1'h0);
		cmp1(quad_b, 1'h1);
		cmp8(stat_b, sfr_pkg::STATUS_DELIVERED);
		test_done();
	end
endmodule
